// ---- core/mio_pkg.sv ----
/*
  mio_pkg: shared constants for the motor io block (register map, field
  positions, reset values, clock-derived cycle counts).
  assumes a single 20 MHz system clock and a 32-bit APB register bus.
*/
package mio_pkg;

  // ==========================================================
  // clock and derived timing
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned INV_PWM_HZ    = 24_000;
  localparam int unsigned SM_PWM_HZ     = 50_000;
  // a period is a longest time: round down
  localparam int unsigned INV_PER       = CLK_HZ / INV_PWM_HZ;
  localparam int unsigned SM_PER        = CLK_HZ / SM_PWM_HZ;
  // duty limits in tenths of a percent
  localparam int unsigned INV_MIN_PERMIL = 2;
  localparam int unsigned SM_MAX_PERMIL  = 996;
  localparam int unsigned INV_MIN       = (INV_PER * INV_MIN_PERMIL) / 1000;
  localparam int unsigned INV_SPAN      = INV_PER - 2 * INV_MIN;
  localparam int unsigned SM_MAX        = (SM_PER * SM_MAX_PERMIL) / 1000;
  localparam int unsigned SAMPLE_US     = 1000;
  localparam int unsigned SAMPLE_CYC    = (CLK_HZ / 1_000_000) * SAMPLE_US;
  localparam int unsigned QUAD_STATES_PER_S = 12_000_000;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_CMD    = 8'h04;
  localparam logic [7:0] OFS_IDLE   = 8'h08;
  localparam logic [7:0] OFS_LIMIT  = 8'h0c;
  localparam logic [7:0] OFS_ERR0   = 8'h10;
  localparam logic [7:0] OFS_ERR1   = 8'h14;
  localparam logic [7:0] OFS_OPORT  = 8'h18;
  localparam logic [7:0] OFS_OSET   = 8'h1c;
  localparam logic [7:0] OFS_OCLR   = 8'h20;
  localparam logic [7:0] OFS_MPOS   = 8'h24;
  localparam logic [7:0] OFS_APOS   = 8'h28;
  localparam logic [7:0] OFS_HOME   = 8'h2c;
  localparam logic [7:0] OFS_STEP   = 8'h30;
  localparam logic [7:0] OFS_SPER   = 8'h34;
  localparam logic [7:0] OFS_ISTAT  = 8'h38;
  localparam logic [7:0] OFS_IMASK  = 8'h3c;
  localparam logic [7:0] OFS_STATE  = 8'h40;

  // ==========================================================
  // ctrl fields
  localparam int CTL_MOTOR_ON = 0;
  localparam int CTL_FMT_LO   = 1;  // [2:1] output format
  localparam int CTL_STEP_POL = 3;  // 1: step pulse active high
  localparam int CTL_ADOF     = 4;  // amp disable on fault
  localparam int CTL_AMP_EN   = 5;
  localparam int CTL_MAIN_PD  = 6;  // main encoder pulse/direction
  localparam int CTL_AUX_PD   = 7;
  localparam int CTL_FIND_IDX = 8;
  localparam int CTL_OUT_EN   = 9;  // drive step/pwm pin
  localparam int CTL_W        = 10;
  localparam logic [CTL_W-1:0] CTL_RST = 10'h000;

  // status / mask bits
  localparam int ST_INDEX = 0;
  localparam int ST_FAULT = 1;
  localparam int ST_ABORT = 2;
  localparam int ST_STEPS = 3;
  localparam int ST_W     = 4;

  localparam logic [15:0] SPER_RST = 16'h0064;
  localparam logic [31:0] LIMIT_RST = 32'h7fff_ffff;

  typedef enum logic [1:0] {
    FMT_INVERTER,
    FMT_SIGN_MAG,
    FMT_STEPPER,
    FMT_ANALOG
  } mio_fmt_type;

endpackage : mio_pkg

// ---- core/mio_quad.sv ----
/*
  mio_quad: one encoder channel pair with index; synchroniser, 4x
  quadrature or pulse/direction decoding, position counter.
  assumes encoder levels arrive asynchronously to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module mio_quad #(
  parameter int POS_W = 32
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_b,
  // encoder pins
  input  wire logic             quadrature_input_a,
  input  wire logic             quadrature_input_b,
  input  wire logic             index_in,
  // configuration
  input  wire logic             pulse_dir_mode,
  // results
  output logic [POS_W-1:0]      pos,
  output logic                  index_rise
);
  import mio_pkg::*;

  // ========================================================
  // synchronisers
  logic [2:0] s1_reg;
  logic [2:0] s2_reg;
  logic [2:0] s3_reg;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_reg <= 3'h0;
      s2_reg <= 3'h0;
      s3_reg <= 3'h0;
    end else begin
      s1_reg <= {index_in, quadrature_input_b, quadrature_input_a}; // [R16]
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // ========================================================
  // decode
  wire a_now = s2_reg[0];
  wire b_now = s2_reg[1];
  wire a_old = s3_reg[0];
  wire b_old = s3_reg[1];
  wire a_chg = a_now ^ a_old;
  wire b_chg = b_now ^ b_old;
  // a leads b: the changing channel ends unequal/equal in fixed pattern
  wire q_step = a_chg ^ b_chg;                    // [R17]
  wire q_up   = a_chg ? (a_now ^ b_now) : (a_now ~^ b_now); // [R10]
  wire pd_step = a_now & ~a_old;                  // [R12]
  wire pd_up   = b_now;
  wire cnt_en = pulse_dir_mode ? pd_step : q_step;
  wire cnt_up = pulse_dir_mode ? pd_up : q_up;

  logic [POS_W-1:0] pos_next;
  assign pos_next = cnt_up ? pos + POS_W'(1) : pos - POS_W'(1);
  assign index_rise = s2_reg[2] & ~s3_reg[2];     // [R13]

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) pos <= '0;
    else if (cnt_en) pos <= pos_next;             // [R10] [R11]
  end

  a_both_ignored: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R17]
    (!pulse_dir_mode && a_chg && b_chg) |=> $stable(pos))
    else $error("double transition changed position");
  a_quad_dir: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R17]
    (!pulse_dir_mode && a_chg && !b_chg && a_now != b_now) |=> pos == $past(pos) + 1)
    else $error("a-leads-b step did not count up");
  a_pd_count: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R12]
    (pulse_dir_mode && a_now && !a_old && !b_now) |=> pos == $past(pos) - 1)
    else $error("pulse with low direction did not count down");
  c_quad_up: cover property (@(posedge ref_clk) disable iff (!rst_b)
    !pulse_dir_mode && q_step && q_up);

endmodule : mio_quad
`default_nettype wire

// ---- core/mio_top.sv ----
/*
  mio_top: axis motor io interface. motor command sampling, inverter and
  sign-magnitude pwm, step/direction generator, amp enable, tracking
  fault, general outputs, main and aux encoder decoding, abort handling.
  assumes an APB master on ref_clk and encoder/abort pins asynchronous.
*/
// Behaviour
// R01: in servo formats the applied command is refreshed once per sample period, or held at the idle level when the motor is off.
// R02: amp enable goes low on abort, and on a tracking fault when amp-disable-on-fault is set.
// R03: inverter pwm switches at 24 kHz with duty 0.2 percent at full negative, 50 percent at zero and 99.8 percent at full positive.
// R04: sign-magnitude pwm switches at 50 kHz with duty 0 to 99.6 percent of magnitude and polarity on the sign pin.
// R05: the sign pin shows command polarity in servo pwm use and step direction in stepper use.
// R06: stepper use emits one 50 percent duty pulse per step with selectable polarity.
// R07: after reset the step/pwm pin is driven low with the sign-magnitude jumper fitted, else left undriven.
// R08: the error output goes low while any axis position error magnitude exceeds the fault limit.
// R09: three general outputs, each set or cleared by a bit command, or all written by a port write.
// R10: quadrature decoding counts every edge, four counts per encoder cycle.
// R11: decoding keeps up with 12,000,000 quadrature states per second.
// R12: in pulse/direction feedback a pulse on a counts one position with direction from b.
// R13: the index pulse defines the home position during a find-index operation.
// R14: an auxiliary encoder is decoded independently of the main one.
// R15: a low abort input stops motion at once without ramp and terminates the motion program.
// R16: encoder and abort inputs pass two synchroniser flip-flops before use.
// R17: quadrature counts up when a leads b, down when b leads a, and ignores double changes.
`timescale 1ns/1ps
`default_nettype none
module mio_top #(
  parameter int unsigned SAMPLE_CYCLES = mio_pkg::SAMPLE_CYC,
  parameter int          POS_W         = 32
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  // drive side
  output logic [15:0]      motor_cmd,
  output logic             pwm_step_out,
  output logic             pwm_step_oe_b,
  output logic             sign_dir_out,
  output logic             amp_enable,
  output logic             error_out_b,
  output logic [2:0]       gen_out,
  output logic             program_abort,
  // straps and encoders
  input  wire logic        sign_magnitude_jumper,
  input  wire logic        quadrature_input_a,
  input  wire logic        quadrature_input_b,
  input  wire logic        index_in,
  input  wire logic        aux_input_a,
  input  wire logic        aux_input_b,
  input  wire logic        abort_in_b
);
  import mio_pkg::*;

  // ==========================================================
  // apb decode
  wire wr_en = psel & penable & pwrite;
  wire rd_en = psel & penable & ~pwrite;
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit
  wire mapped = (paddr[1:0] == 2'b00) && (paddr <= OFS_STATE);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  logic [CTL_W-1:0]  ctrl_reg;
  logic [15:0]       cmd_reg;
  logic [15:0]       idle_output_level;
  logic [31:0]       tracking_fault_limit;
  logic [31:0]       err0_reg;
  logic [31:0]       err1_reg;
  logic [2:0]        out_reg;
  logic [POS_W-1:0]  home_reg;
  logic [15:0]       sper_reg;
  logic [ST_W-1:0]   stat_reg;
  logic [ST_W-1:0]   mask_reg;
  logic              jumper_reg;
  logic              jumper_taken_reg;
  logic              pin_live_reg;

  wire [1:0] fmt_bits = ctrl_reg[CTL_FMT_LO+1:CTL_FMT_LO];
  wire stepper  = (fmt_bits == 2'(FMT_STEPPER));
  wire inverter = (fmt_bits == 2'(FMT_INVERTER));
  wire signmag  = (fmt_bits == 2'(FMT_SIGN_MAG));

  // ==========================================================
  // abort synchroniser
  logic ab1_reg;
  logic ab2_reg;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ab1_reg <= 1'b1;
      ab2_reg <= 1'b1;
    end else begin
      ab1_reg <= abort_in_b;                       // [R16]
      ab2_reg <= ab1_reg;
    end
  end
  wire abort_now = ~ab2_reg;
  assign program_abort = abort_now;                // [R15]

  // ==========================================================
  // encoders
  logic [POS_W-1:0] main_pos;
  logic [POS_W-1:0] aux_pos;
  logic             main_index;
  mio_quad #(.POS_W(POS_W)) u_main (
    .ref_clk            (ref_clk),
    .rst_b              (rst_b),
    .quadrature_input_a (quadrature_input_a),
    .quadrature_input_b (quadrature_input_b),
    .index_in           (index_in),
    .pulse_dir_mode     (ctrl_reg[CTL_MAIN_PD]),
    .pos                (main_pos),
    .index_rise         (main_index)
  );
  // aux has no index; its own counter and mode keep it independent
  mio_quad #(.POS_W(POS_W)) u_aux (               // [R14]
    .ref_clk            (ref_clk),
    .rst_b              (rst_b),
    .quadrature_input_a (aux_input_a),
    .quadrature_input_b (aux_input_b),
    .index_in           (1'b0),
    .pulse_dir_mode     (ctrl_reg[CTL_AUX_PD]),
    .pos                (aux_pos),
    .index_rise         ()
  );
  wire home_hit = ctrl_reg[CTL_FIND_IDX] & main_index; // [R13]

  // ==========================================================
  // tracking fault
  function automatic logic [31:0] mag32(input logic [31:0] v);
    mag32 = v[31] ? 32'(-v) : v;
  endfunction : mag32
  wire fault = (mag32(err0_reg) > tracking_fault_limit) |
               (mag32(err1_reg) > tracking_fault_limit); // [R08]
  assign error_out_b = ~fault;                     // [R08]
  assign amp_enable  = ctrl_reg[CTL_AMP_EN] & ~abort_now &
                       ~(ctrl_reg[CTL_ADOF] & fault); // [R02]

  // ==========================================================
  // servo sample tick and applied command
  logic [31:0] samp_cnt_reg;
  wire samp_tick = (samp_cnt_reg == 32'(SAMPLE_CYCLES - 1));
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) samp_cnt_reg <= 32'h0000_0000;
    else samp_cnt_reg <= samp_tick ? 32'h0000_0000 : samp_cnt_reg + 32'h0000_0001;
  end
  // abort zeroes the command at once rather than waiting for a tick
  logic [15:0] cmd_next;
  assign cmd_next = abort_now ? 16'h0000 :
                    ctrl_reg[CTL_MOTOR_ON] ? cmd_reg : idle_output_level; // [R01] [R15]
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) motor_cmd <= 16'h0000;
    else if (samp_tick | abort_now) motor_cmd <= cmd_next; // [R01]
  end

  // ==========================================================
  // pwm
  logic [9:0] pwm_cnt_reg;
  wire [9:0] pwm_per = inverter ? 10'(INV_PER) : 10'(SM_PER);
  wire pwm_wrap = (pwm_cnt_reg >= pwm_per - 10'd1);
  // offset binary: flipping the sign bit maps full negative to zero
  wire [16:0] cmd_ofs = {1'b0, ~motor_cmd[15], motor_cmd[14:0]};
  wire [15:0] cmd_mag = motor_cmd[15] ? 16'(-motor_cmd) : motor_cmd;
  wire [26:0] inv_prod = 27'(cmd_ofs) * 27'(INV_SPAN);
  wire [26:0] sm_prod  = 27'(cmd_mag) * 27'(SM_MAX);
  wire [9:0] inv_hi = 10'(INV_MIN) + inv_prod[25:16];   // [R03]
  wire [9:0] sm_hi  = sm_prod[24:15];                   // [R04]
  wire [9:0] pwm_hi = inverter ? inv_hi : sm_hi;
  logic pwm_reg;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) pwm_cnt_reg <= 10'h000;
    else pwm_cnt_reg <= pwm_wrap ? 10'h000 : pwm_cnt_reg + 10'h001; // [R03] [R04]
  end
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) pwm_reg <= 1'b0;
    else pwm_reg <= (pwm_cnt_reg < pwm_hi);
  end

  // ==========================================================
  // stepper
  logic [15:0] steps_left_reg;
  logic        step_dir_reg;
  logic [15:0] step_cnt_reg;
  logic        step_pulse_reg;
  wire step_busy = stepper & (steps_left_reg != 16'h0000);
  wire step_end  = step_busy & (step_cnt_reg >= sper_reg - 16'h0001);
  wire step_wr   = wr_en & hit(paddr, OFS_STEP);
  wire steps_done = step_end & (steps_left_reg == 16'h0001);
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      steps_left_reg <= 16'h0000;
      step_dir_reg   <= 1'b0;
      step_cnt_reg   <= 16'h0000;
    end else if (abort_now) begin
      steps_left_reg <= 16'h0000;                  // [R15]
      step_cnt_reg   <= 16'h0000;
    end else if (step_wr) begin
      steps_left_reg <= pwdata[15:0];
      step_dir_reg   <= pwdata[16];
      step_cnt_reg   <= 16'h0000;
    end else if (step_busy) begin
      step_cnt_reg <= step_end ? 16'h0000 : step_cnt_reg + 16'h0001;
      if (step_end) steps_left_reg <= steps_left_reg - 16'h0001;
    end
  end
  // first half of each step period is the active half
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) step_pulse_reg <= 1'b0;
    else step_pulse_reg <= step_busy & (step_cnt_reg < {1'b0, sper_reg[15:1]}); // [R06]
  end

  // ==========================================================
  // pin muxing
  wire step_level = ctrl_reg[CTL_STEP_POL] ? step_pulse_reg : ~step_pulse_reg; // [R06]
  // pin rests low after reset until software first writes the ctrl register
  assign pwm_step_out  = (!pin_live_reg) ? 1'b0 :     // [R07]
                         stepper ? step_level :
                         (inverter | signmag) ? pwm_reg : 1'b0;
  // jumper strap caught on the first clocked edge after release
  assign pwm_step_oe_b = ~(jumper_reg | ctrl_reg[CTL_OUT_EN]); // [R07]
  assign sign_dir_out  = stepper ? step_dir_reg : motor_cmd[15]; // [R05]
  assign gen_out       = out_reg;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      jumper_reg       <= 1'b0;
      jumper_taken_reg <= 1'b0;
    end else if (!jumper_taken_reg) begin
      jumper_reg       <= sign_magnitude_jumper;   // [R07]
      jumper_taken_reg <= 1'b1;
    end
  end

  // ==========================================================
  // register writes
  wire [ST_W-1:0] events;
  assign events[ST_INDEX] = home_hit;
  assign events[ST_FAULT] = fault;
  assign events[ST_ABORT] = abort_now;
  assign events[ST_STEPS] = steps_done;
  wire [ST_W-1:0] w1c = (wr_en & hit(paddr, OFS_ISTAT)) ? pwdata[ST_W-1:0] : '0;
  wire [2:0] out_next = hit(paddr, OFS_OPORT) ? pwdata[2:0] :
                        hit(paddr, OFS_OSET)  ? (out_reg | pwdata[2:0]) :
                        hit(paddr, OFS_OCLR)  ? (out_reg & ~pwdata[2:0]) : out_reg; // [R09]

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_reg             <= CTL_RST;
      cmd_reg              <= 16'h0000;
      idle_output_level    <= 16'h0000;
      tracking_fault_limit <= LIMIT_RST;
      err0_reg             <= 32'h0000_0000;
      err1_reg             <= 32'h0000_0000;
      out_reg              <= 3'h0;
      sper_reg             <= SPER_RST;
      mask_reg             <= '0;
      pin_live_reg         <= 1'b0;
    end else begin
      if (wr_en) begin
        if (hit(paddr, OFS_CTRL)) ctrl_reg <= pwdata[CTL_W-1:0];
        else if (hit(paddr, OFS_CMD)) cmd_reg <= pwdata[15:0];
        else if (hit(paddr, OFS_IDLE)) idle_output_level <= pwdata[15:0];
        else if (hit(paddr, OFS_LIMIT)) tracking_fault_limit <= pwdata;
        else if (hit(paddr, OFS_ERR0)) err0_reg <= pwdata;
        else if (hit(paddr, OFS_ERR1)) err1_reg <= pwdata;
        else if (hit(paddr, OFS_SPER)) sper_reg <= pwdata[15:0];
        else if (hit(paddr, OFS_IMASK)) mask_reg <= pwdata[ST_W-1:0];
        out_reg <= out_next;                       // [R09]
        if (hit(paddr, OFS_CTRL)) pin_live_reg <= 1'b1; // [R07]
      end
      // find-index disarms itself once home is taken
      if (home_hit) ctrl_reg[CTL_FIND_IDX] <= 1'b0; // [R13]
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      home_reg <= '0;
      stat_reg <= '0;
    end else begin
      if (home_hit) home_reg <= main_pos;          // [R13]
      stat_reg <= (stat_reg & ~w1c) | events;      // set wins over clear
    end
  end
  assign irq = |(stat_reg & mask_reg);

  // ==========================================================
  // read mux
  wire [31:0] state_word = {24'h00_0000, step_busy, jumper_reg, fault,
                            amp_enable, abort_now, gen_out};
  assign prdata = !rd_en ? 32'h0000_0000 :
    hit(paddr, OFS_CTRL)  ? 32'(ctrl_reg) :
    hit(paddr, OFS_CMD)   ? {16'h0000, cmd_reg} :
    hit(paddr, OFS_IDLE)  ? {16'h0000, idle_output_level} :
    hit(paddr, OFS_LIMIT) ? tracking_fault_limit :
    hit(paddr, OFS_ERR0)  ? err0_reg :
    hit(paddr, OFS_ERR1)  ? err1_reg :
    hit(paddr, OFS_OPORT) ? {29'h0000_0000, out_reg} :
    hit(paddr, OFS_MPOS)  ? 32'(main_pos) :
    hit(paddr, OFS_APOS)  ? 32'(aux_pos) :
    hit(paddr, OFS_HOME)  ? 32'(home_reg) :
    hit(paddr, OFS_STEP)  ? {15'h0000, step_dir_reg, steps_left_reg} :
    hit(paddr, OFS_SPER)  ? {16'h0000, sper_reg} :
    hit(paddr, OFS_ISTAT) ? 32'(stat_reg) :
    hit(paddr, OFS_IMASK) ? 32'(mask_reg) :
    hit(paddr, OFS_STATE) ? state_word : 32'h0000_0000;

  // ==========================================================
  // checks
  a_amp_abort: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R02]
    abort_now |-> !amp_enable)
    else $error("amp enable high during abort");
  a_amp_fault: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R02]
    (ctrl_reg[CTL_ADOF] && fault) |-> !amp_enable)
    else $error("amp enable high on fault");
  a_err_pin: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R08]
    (mag32(err0_reg) > tracking_fault_limit) |-> !error_out_b)
    else $error("error pin not low on fault");
  a_cmd_hold: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R01]
    (!samp_tick && !abort_now) |=> $stable(motor_cmd))
    else $error("command changed between samples");
  a_cmd_idle: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R01]
    (samp_tick && !abort_now && !ctrl_reg[CTL_MOTOR_ON]) |=> motor_cmd == $past(idle_output_level))
    else $error("idle level not applied");
  a_abort_stop: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R15]
    abort_now |=> (motor_cmd == 16'h0000) && (steps_left_reg == 16'h0000))
    else $error("abort did not stop motion");
  a_pwm_period: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R03]
    (inverter && pwm_cnt_reg == 10'(INV_PER - 1) && $stable(inverter)) |=> pwm_cnt_reg == 10'h000)
    else $error("inverter period wrong");
  a_sign_pin: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R05]
    (signmag || inverter) |-> sign_dir_out == motor_cmd[15])
    else $error("sign pin not command polarity");
  a_strap_drive: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R07]
    (jumper_taken_reg && jumper_reg) |-> !pwm_step_oe_b)
    else $error("jumper fitted but pin undriven");
  a_port_set: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R09]
    (wr_en && hit(paddr, OFS_OSET)) |=> (gen_out & $past(pwdata[2:0])) == $past(pwdata[2:0]))
    else $error("bit set lost");

  c_step_done: cover property (@(posedge ref_clk) disable iff (!rst_b) steps_done);
  c_home_found: cover property (@(posedge ref_clk) disable iff (!rst_b) home_hit);
  c_fault_irq: cover property (@(posedge ref_clk) disable iff (!rst_b) fault ##1 irq);

endmodule : mio_top
`default_nettype wire

// ---- dv/mio_enc_model.sv ----
/*
  mio_enc_model: incremental encoder facing the axis encoder pins.
  assumes move requests one cycle long and at least three cycles apart.
*/
`timescale 1ns/1ps
`default_nettype none
module mio_enc_model (
  // clock
  input  wire logic ref_clk,
  // move request
  input  wire logic mv,
  input  wire logic dn,
  // encoder pins
  output logic      a,
  output logic      b
);
  logic [1:0] ph_reg = 2'h0;
  // ==========================================================
  // gray walk: a leads b going up, one channel changes per step
  always @(posedge ref_clk) begin
    if (mv) ph_reg <= dn ? ph_reg - 2'h1 : ph_reg + 2'h1;
  end
  assign a = ph_reg[0] ^ ph_reg[1];
  assign b = ph_reg[1];
endmodule : mio_enc_model
`default_nettype wire

// ---- dv/tb_motor_io_interface.sv ----
/*
  tb_motor_io_interface: self-checking bench for mio_top over apb.
  assumes a zero-wait apb slave and two encoder models on the pins.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_motor_io_interface;
  import mio_pkg::*;
  logic        ref_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        abort_in_b = 1'b1, mvm = 1'b0, mva = 1'b0, dn = 1'b0, idx = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q, serr;
  logic        pready, pslverr, irq, pso, poe, sdo, amp, eob, pab, qa, qb, xa, xb;
  logic [15:0] motor_cmd;
  logic [2:0]  gen_out;
  int          error_cnt = 0, check_count = 0, n, cnt, prev;
  logic [71:0] rows [5] = '{{OFS_CMD, 32'h0001_8001, 32'h0000_8001},
    {OFS_LIMIT, 32'h0000_0010, 32'h0000_0010}, {OFS_SPER, 32'h0000_0004, 32'h0000_0004},
    {OFS_IMASK, 32'h0000_00ff, 32'h0000_000f}, {OFS_OSET, 32'h0000_0001, 32'h0000_0000}};
  always #25 ref_clk = ~ref_clk;
  // ==========================================================
  // design and encoders; short sample period keeps the run brief
  mio_top #(.SAMPLE_CYCLES(20)) uut (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .motor_cmd(motor_cmd),
    .pwm_step_out(pso), .pwm_step_oe_b(poe), .sign_dir_out(sdo), .amp_enable(amp),
    .error_out_b(eob), .gen_out(gen_out), .program_abort(pab), .sign_magnitude_jumper(1'b1),
    .quadrature_input_a(qa), .quadrature_input_b(qb), .index_in(idx),
    .aux_input_a(xa), .aux_input_b(xb), .abort_in_b(abort_in_b));
  mio_enc_model enc_m (.ref_clk(ref_clk), .mv(mvm), .dn(dn), .a(qa), .b(qb));
  mio_enc_model enc_x (.ref_clk(ref_clk), .mv(mva), .dn(dn), .a(xa), .b(xb));
  // ==========================================================
  // tasks
  task close_out;
    if (error_cnt == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      $display("MISMATCH %s exp %h got %h", nm, e, s);
      error_cnt++;
    end
  endtask : chk
  // request held until pready seen at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge ref_clk); n++; end while (pready !== 1'b1 && n < 20);
    q = prdata;
    serr = 32'(pslverr);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20) error_cnt++;
    if (n == 20) close_out;
    @(negedge ref_clk);
  endtask : apb
  task mov(input logic x, input logic d, input int k);
    repeat (k) begin
      @(posedge ref_clk);
      mvm <= ~x;
      mva <= x;
      dn <= d;
      @(posedge ref_clk);
      mvm <= 1'b0;
      mva <= 1'b0;
      repeat (3) @(posedge ref_clk);
    end
  endtask : mov
  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    close_out;
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (3) @(negedge ref_clk);
    chk("amp_rst", 32'h0, 32'(amp));
    chk("err_rst", 32'h1, 32'(eob));
    @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (3) @(negedge ref_clk);
    chk("oe_b", 32'h0, 32'(poe));
    chk("pin", 32'h0, 32'(pso));
    apb(1'b0, OFS_LIMIT, 32'h0);
    chk("limit", 32'h7fff_ffff, q);
    foreach (rows[i]) begin
      apb(1'b1, rows[i][71:64], rows[i][63:32]);
      apb(1'b0, rows[i][71:64], 32'h0);
      chk("row", rows[i][31:0], q);
    end
    apb(1'b1, OFS_OPORT, 32'h0000_0005);
    chk("port", 32'h5, 32'(gen_out));
    apb(1'b1, OFS_OSET, 32'h0000_0002);
    chk("set", 32'h7, 32'(gen_out));
    apb(1'b1, OFS_OCLR, 32'h0000_0004);
    chk("clr", 32'h3, 32'(gen_out));
    apb(1'b1, OFS_CTRL, 32'h0000_0031);
    chk("amp_on", 32'h1, 32'(amp));
    apb(1'b1, OFS_ERR0, 32'h0000_0011);
    chk("err_lo", 32'h0, 32'(eob));
    chk("amp_flt", 32'h0, 32'(amp));
    @(negedge ref_clk);
    chk("irq", 32'h1, 32'(irq));
    apb(1'b1, OFS_IMASK, 32'h0000_0000);
    chk("irq_mask", 32'h0, 32'(irq));
    apb(1'b1, OFS_IMASK, 32'h0000_000f);
    apb(1'b1, OFS_ERR0, 32'hffff_fff0);
    chk("err_edge", 32'h1, 32'(eob));
    apb(1'b1, OFS_ISTAT, 32'h0000_0002);
    chk("irq_clr", 32'h0, 32'(irq));
    apb(1'b1, OFS_CMD, 32'h0000_1234);
    repeat (25) @(negedge ref_clk);
    chk("cmd", 32'h1234, 32'(motor_cmd));
    chk("sign_p", 32'h0, 32'(sdo));
    apb(1'b1, OFS_CTRL, 32'h0000_0030);
    apb(1'b1, OFS_IDLE, 32'h0000_ff00);
    repeat (25) @(negedge ref_clk);
    chk("idle", 32'hff00, 32'(motor_cmd));
    chk("sign_n", 32'h1, 32'(sdo));
    apb(1'b1, OFS_CTRL, 32'h0000_000c);
    apb(1'b1, OFS_STEP, 32'h0001_0003);
    cnt = 0;
    prev = 0;
    repeat (40) begin @(negedge ref_clk); cnt += int'(pso & ~prev[0]); prev = pso; end
    chk("steps", 32'h3, 32'(cnt));
    chk("dir", 32'h1, 32'(sdo));
    apb(1'b0, OFS_ISTAT, 32'h0);
    chk("done", 32'h0000_0008, q);
    apb(1'b1, OFS_CTRL, 32'h0000_0021);
    @(posedge ref_clk);
    abort_in_b <= 1'b0;
    repeat (6) @(negedge ref_clk);
    chk("abort", 32'h1, 32'(pab));
    chk("amp_ab", 32'h0, 32'(amp));
    chk("cmd_ab", 32'h0, 32'(motor_cmd));
    @(posedge ref_clk);
    abort_in_b <= 1'b1;
    mov(1'b0, 1'b0, 8);
    apb(1'b0, OFS_MPOS, 32'h0);
    chk("mpos", 32'h0000_0008, q);
    mov(1'b1, 1'b1, 3);
    apb(1'b0, OFS_APOS, 32'h0);
    chk("apos", 32'hffff_fffd, q);
    apb(1'b1, OFS_CTRL, 32'h0000_0180);
    @(posedge ref_clk);
    idx <= 1'b1;
    mov(1'b1, 1'b0, 4);
    apb(1'b0, OFS_HOME, 32'h0);
    chk("home", 32'h0000_0008, q);
    apb(1'b0, OFS_APOS, 32'h0);
    chk("apos_pd", 32'hffff_fffc, q);
    apb(1'b0, 8'h44, 32'h0);
    chk("slverr", 32'h1, serr);
    close_out;
  end
endmodule : tb_motor_io_interface
`default_nettype wire
